// file: cache_err_pkg.sv
package cache_err_pkg;

  // Datapath geometry
  localparam int unsigned DATA_W    = 64;
  localparam int unsigned DATA_BYTES = DATA_W / 8;
  localparam int unsigned TAG_W     = 21;
  localparam int unsigned TAG_RAMS  = 8;

  // Sticky interrupt line positions
  localparam int unsigned N_IRQ          = 6;
  localparam int unsigned IRQ_TAG_RD_PAR = 0;
  localparam int unsigned IRQ_TAG_RD_ERR = 1;
  localparam int unsigned IRQ_DAT_RD_PAR = 2;
  localparam int unsigned IRQ_DAT_RD_ERR = 3;
  localparam int unsigned IRQ_DAT_WR_ERR = 4;
  localparam int unsigned IRQ_TAG_WR_ERR = 5;
  localparam int unsigned N_EXT_IRQ      = 3;

  // Values after reset
  localparam logic                  IRQ_RESET    = 1'b0;
  localparam logic [DATA_BYTES-1:0] PAR_RESET    = 8'h00;
  localparam logic                  RESULT_RESET = 1'b0;

  // Operation that issued the RAM access
  typedef enum logic [2:0] {
    OP_SLAVE_READ = 3'h0,
    OP_SB_WRITE   = 3'h1,
    OP_ALLOC      = 3'h2,
    OP_CLEAN      = 3'h3,
    OP_INVAL      = 3'h4,
    OP_CLEAN_INV  = 3'h5
  } op_e;

  // RAM access phase inside that operation
  typedef enum logic [1:0] {
    PH_TAG_READ   = 2'h0,
    PH_DATA_READ  = 2'h1,
    PH_TAG_WRITE  = 2'h2,
    PH_DATA_WRITE = 2'h3
  } phase_e;

  // One completed RAM access, reported on the cycle its data returns
  typedef struct packed {
    logic                  valid;
    op_e                   op;
    phase_e                phase;
    logic                  write_back;
    logic [DATA_W-1:0]     rd_data;
    logic [DATA_BYTES-1:0] rd_par;
  } ram_access_s;

  // Verdict on the operation
  typedef struct packed {
    logic cancel;
    logic skip_evict;
    logic mark_dirty;
  } op_result_s;

  // Write data heading to the RAMs
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [TAG_W-1:0]  tag;
  } ram_write_s;

endpackage

// file: byte_parity.sv
`timescale 1ns/1ps
module byte_parity #(
  parameter int unsigned BYTES = 8
) (
  input  wire logic [BYTES*8-1:0] data,   // Bytes to cover
  output logic      [BYTES-1:0]   parity  // Even parity, one bit per byte
);

  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_byte
      assign parity[i] = ^data[i*8 +: 8];
    end
  endgenerate

endmodule

// file: sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
  input  wire logic clk,     // Clock
  input  wire logic rstn,    // Async reset, active low
  input  wire logic set,     // Event pulse
  input  wire logic clr,     // Clear pulse
  output logic      flag_d,  // Next value
  output logic      flag_q   // Sticky flag
);
  import cache_err_pkg::*;

  // Set beats a clear in the same cycle
  always_comb begin
    flag_d = set | (flag_q & ~clr);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= IRQ_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// file: cache_ram_error_reporting.sv
// Summary of operation
// - Slave read tag lookup parity or RAM fault raises tag-read parity/error line.
// - Slave read data RAM fault is reported on the tag-read parity/error pair.
// - Store-buffer write tag fault raises tag-read line and cancels the cache write.
// - Store-buffer data write fault raises data-write line; write-back still marks dirty.
// - Allocation victim tag read fault raises tag-read line and abandons allocation.
// - Allocation eviction data read fault raises data-read line; RAM error skips eviction.
// - Allocation tag write RAM fault raises tag-write error line.
// - Allocation data write RAM fault raises data-write error line.
// - Clean tag read fault raises tag-read line and cancels the clean.
// - Clean data read fault raises data-read line; clean completes, RAM error skips eviction.
// - Invalidate tag read fault raises tag-read line and cancels the invalidate.
// - Invalidate or clean-invalidate valid-bit tag write fault raises tag-write error line.
// - Clean-invalidate tag read fault raises tag-read line and cancels the operation.
// - Clean-invalidate data read fault raises data-read line; RAM error skips eviction.
// - RAM error inputs are handled like detected parity errors, but only RAM errors skip eviction or flag write phases.
// - Data RAM write parity is generated per byte.
// - Every error interrupt line is sticky until cleared.
// - Combined interrupt is the OR of all nine interrupt lines.
`timescale 1ns/1ps
module cache_ram_error_reporting (
  input  wire logic                                clk,                  // 25 MHz clock
  input  wire logic                                rstn,                 // Async reset, active low
  input  cache_err_pkg::ram_access_s               access,               // Completed RAM access
  input  wire logic                                data_ram_error_in,    // Data RAM error
  input  wire logic [cache_err_pkg::TAG_RAMS-1:0]  tag_ram_error_in,     // Tag RAM errors
  input  cache_err_pkg::ram_write_s                wr,                   // RAM write data
  input  wire logic [cache_err_pkg::N_IRQ-1:0]     irq_clear,            // Clear pulses per line
  input  wire logic [cache_err_pkg::N_EXT_IRQ-1:0] ext_irq,              // Other three lines
  output logic                                     tag_read_parity_irq,  // Tag read parity
  output logic                                     tag_read_error_irq,   // Tag read RAM error
  output logic                                     data_read_parity_irq, // Data read parity
  output logic                                     data_read_error_irq,  // Data read RAM error
  output logic                                     data_write_error_irq, // Data write RAM error
  output logic                                     tag_write_error_irq,  // Tag write RAM error
  output logic                                     combined_irq,         // OR of nine lines
  output cache_err_pkg::op_result_s                result,               // Operation verdict
  output logic [cache_err_pkg::DATA_BYTES-1:0]     data_wr_par,          // Data write parity
  output logic                                     tag_wr_par            // Tag write parity
);
  import cache_err_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parity check on read data and parity generation for writes

  logic [DATA_BYTES-1:0] rd_par_calc;
  logic [DATA_BYTES-1:0] wr_par_calc;
  logic                  tag_par_bad;
  logic                  data_par_bad;

  byte_parity #(.BYTES(DATA_BYTES)) u_rd_par (
    .data   (access.rd_data),
    .parity (rd_par_calc)
  );

  byte_parity #(.BYTES(DATA_BYTES)) u_wr_par (
    .data   (wr.data),
    .parity (wr_par_calc)
  );

  always_comb begin
    tag_par_bad  = (^access.rd_data[TAG_W-1:0]) ^ access.rd_par[0];
    data_par_bad = |(rd_par_calc ^ access.rd_par);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error classification and verdict

  logic             is_tag;
  logic             par_err;
  logic             ram_err;
  logic             any_err;
  logic [N_IRQ-1:0] irq_set;
  op_result_s       result_d;
  op_result_s       result_q;

  always_comb begin
    is_tag   = (access.phase == PH_TAG_READ) || (access.phase == PH_TAG_WRITE);
    ram_err  = is_tag ? |tag_ram_error_in : data_ram_error_in;
    par_err  = 1'b0;
    if (access.phase == PH_TAG_READ) begin
      par_err = tag_par_bad;
    end else if (access.phase == PH_DATA_READ) begin
      par_err = data_par_bad;
    end
    any_err  = par_err | ram_err;
    irq_set  = '0;
    result_d = '0;
    if (access.valid) begin
      case (access.phase)
        PH_TAG_READ: begin
          irq_set[IRQ_TAG_RD_PAR] = par_err;
          irq_set[IRQ_TAG_RD_ERR] = ram_err;
          if (access.op != OP_SLAVE_READ) begin
            result_d.cancel = any_err;
          end
        end
        PH_DATA_READ: begin
          if (access.op == OP_SLAVE_READ) begin
            irq_set[IRQ_TAG_RD_PAR] = par_err;
            irq_set[IRQ_TAG_RD_ERR] = ram_err;
          end else begin
            irq_set[IRQ_DAT_RD_PAR] = par_err;
            irq_set[IRQ_DAT_RD_ERR] = ram_err;
            if (access.op == OP_ALLOC || access.op == OP_CLEAN || access.op == OP_CLEAN_INV) begin
              result_d.skip_evict = ram_err;
            end
          end
        end
        PH_TAG_WRITE: begin
          irq_set[IRQ_TAG_WR_ERR] = ram_err;
        end
        PH_DATA_WRITE: begin
          irq_set[IRQ_DAT_WR_ERR] = ram_err;
          result_d.mark_dirty     = (access.op == OP_SB_WRITE) && access.write_back;
        end
        default: begin
          irq_set = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_q <= '{cancel: RESULT_RESET, skip_evict: RESULT_RESET, mark_dirty: RESULT_RESET};
    end else begin
      result_q <= result_d;
    end
  end

  assign result = result_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt lines

  logic [N_IRQ-1:0] flag_d;
  logic [N_IRQ-1:0] flag_q;

  genvar g;
  generate
    for (g = 0; g < N_IRQ; g++) begin : g_irq
      sticky_flag u_flag (
        .clk    (clk),
        .rstn   (rstn),
        .set    (irq_set[g]),
        .clr    (irq_clear[g]),
        .flag_d (flag_d[g]),
        .flag_q (flag_q[g])
      );
    end
  endgenerate

  assign tag_read_parity_irq  = flag_q[IRQ_TAG_RD_PAR];
  assign tag_read_error_irq   = flag_q[IRQ_TAG_RD_ERR];
  assign data_read_parity_irq = flag_q[IRQ_DAT_RD_PAR];
  assign data_read_error_irq  = flag_q[IRQ_DAT_RD_ERR];
  assign data_write_error_irq = flag_q[IRQ_DAT_WR_ERR];
  assign tag_write_error_irq  = flag_q[IRQ_TAG_WR_ERR];

  ////////////////////////////////////////////////////////////////////////////
  // Combined line and write parity registers

  logic                  combined_d;
  logic                  combined_q;
  logic [DATA_BYTES-1:0] data_wr_par_d;
  logic [DATA_BYTES-1:0] data_wr_par_q;
  logic                  tag_wr_par_d;
  logic                  tag_wr_par_q;

  always_comb begin
    combined_d    = |flag_d | |ext_irq;
    data_wr_par_d = wr_par_calc;
    tag_wr_par_d  = ^wr.tag;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      combined_q    <= IRQ_RESET;
      data_wr_par_q <= PAR_RESET;
      tag_wr_par_q  <= RESULT_RESET;
    end else begin
      combined_q    <= combined_d;
      data_wr_par_q <= data_wr_par_d;
      tag_wr_par_q  <= tag_wr_par_d;
    end
  end

  assign combined_irq = combined_q;
  assign data_wr_par  = data_wr_par_q;
  assign tag_wr_par   = tag_wr_par_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_tag_read_flag: assert property (
    access.valid && access.phase == PH_TAG_READ && |tag_ram_error_in |=> tag_read_error_irq
  ) else $error("tag read RAM error not flagged");

  a_slave_data_pair: assert property (
    access.valid && access.op == OP_SLAVE_READ && access.phase == PH_DATA_READ && data_ram_error_in
    |=> tag_read_error_irq && !$rose(data_read_error_irq)
  ) else $error("slave read data error not on tag-read pair");

  a_tag_read_cancel: assert property (
    access.valid && access.op != OP_SLAVE_READ && access.phase == PH_TAG_READ
    && (|tag_ram_error_in || tag_par_bad) |=> result.cancel
  ) else $error("tag read fault did not cancel");

  a_dirty_on_error: assert property (
    access.valid && access.op == OP_SB_WRITE && access.phase == PH_DATA_WRITE
    && access.write_back && data_ram_error_in |=> result.mark_dirty && data_write_error_irq
  ) else $error("write-back line not marked dirty on write error");

  a_skip_evict_only: assert property (
    access.valid && access.phase == PH_DATA_READ && access.op != OP_SLAVE_READ
    |=> result.skip_evict == ($past(data_ram_error_in) && $past(access.op) inside {OP_ALLOC, OP_CLEAN, OP_CLEAN_INV})
    && !result.cancel
  ) else $error("eviction skip wrong");

  a_tag_write_err: assert property (
    access.valid && access.phase == PH_TAG_WRITE && |tag_ram_error_in |=> tag_write_error_irq
  ) else $error("tag write error not flagged");

  a_parity_like_error: assert property (
    access.valid && access.op == OP_ALLOC && access.phase == PH_DATA_READ && data_par_bad
    |=> data_read_parity_irq
  ) else $error("data read parity not flagged");

  a_write_parity: assert property (
    1'b1 |=> data_wr_par[0] == ^$past(wr.data[7:0]) && data_wr_par[DATA_BYTES-1] == ^$past(wr.data[DATA_W-1 -: 8])
  ) else $error("data write parity wrong");

  a_sticky_hold: assert property (
    data_write_error_irq && !irq_clear[IRQ_DAT_WR_ERR] |=> data_write_error_irq
  ) else $error("sticky line dropped without clear");

  a_combined_or: assert property (
    1'b1 |-> combined_irq == (|flag_q || |$past(ext_irq))
  ) else $error("combined line differs from OR of lines");

  a_tag_par_flag: assert property (
    access.valid && access.phase == PH_TAG_READ && tag_par_bad |=> tag_read_parity_irq
  ) else $error("tag read parity not flagged");

  a_slave_no_cancel: assert property (
    access.valid && access.op == OP_SLAVE_READ |=> !result.cancel && !result.skip_evict
  ) else $error("slave read verdict not clear");

  a_alloc_abandon: assert property (
    access.valid && access.op == OP_ALLOC && access.phase == PH_TAG_READ && (|tag_ram_error_in || tag_par_bad)
    |=> result.cancel && (tag_read_parity_irq || tag_read_error_irq)
  ) else $error("allocation not abandoned on tag fault");

  a_alloc_skip_evict: assert property (
    access.valid && access.op == OP_ALLOC && access.phase == PH_DATA_READ && data_ram_error_in
    |=> result.skip_evict && data_read_error_irq && !result.cancel
  ) else $error("allocation eviction not skipped");

  a_alloc_tag_write: assert property (
    access.valid && access.op == OP_ALLOC && access.phase == PH_TAG_WRITE && |tag_ram_error_in
    |=> tag_write_error_irq && !result.cancel
  ) else $error("allocation tag write error not flagged");

  a_data_write_err: assert property (
    access.valid && access.phase == PH_DATA_WRITE && data_ram_error_in |=> data_write_error_irq
  ) else $error("data write error not flagged");

  a_clean_cancel: assert property (
    access.valid && access.op == OP_CLEAN && access.phase == PH_TAG_READ && (|tag_ram_error_in || tag_par_bad)
    |=> result.cancel
  ) else $error("clean not cancelled on tag fault");

  a_clean_completes: assert property (
    access.valid && access.op == OP_CLEAN && access.phase == PH_DATA_READ && (data_par_bad || data_ram_error_in)
    |=> !result.cancel && (data_read_parity_irq || data_read_error_irq)
  ) else $error("clean data fault handled wrong");

  a_inval_cancel: assert property (
    access.valid && access.op == OP_INVAL && access.phase == PH_TAG_READ && (|tag_ram_error_in || tag_par_bad)
    |=> result.cancel
  ) else $error("invalidate not cancelled on tag fault");

  a_clean_inv_cancel: assert property (
    access.valid && access.op == OP_CLEAN_INV && access.phase == PH_TAG_READ && (|tag_ram_error_in || tag_par_bad)
    |=> result.cancel
  ) else $error("clean-invalidate not cancelled on tag fault");

  a_clean_inv_evict: assert property (
    access.valid && access.op == OP_CLEAN_INV && access.phase == PH_DATA_READ && data_ram_error_in
    |=> result.skip_evict && data_read_error_irq && !result.cancel
  ) else $error("clean-invalidate eviction not skipped");

  a_no_dirty_through: assert property (
    access.valid && access.op == OP_SB_WRITE && access.phase == PH_DATA_WRITE && !access.write_back
    |=> !result.mark_dirty && !result.cancel
  ) else $error("write-through line marked dirty");

  a_no_false_set: assert property (
    !access.valid |=> (flag_q & ~$past(flag_q)) == '0
  ) else $error("interrupt line rose without an access");

endmodule

// file: ram_side_model.sv
`timescale 1ns/1ps
module ram_side_model (
  input  wire logic                               clk,               // Clock
  output cache_err_pkg::ram_access_s              access,            // Completed access report
  output logic                                    data_ram_error_in, // Data RAM error
  output logic [cache_err_pkg::TAG_RAMS-1:0]      tag_ram_error_in   // Tag RAM errors
);
  import cache_err_pkg::*;

  logic [DATA_W-1:0] pat;

  initial begin
    pat               = 64'h0123_4567_89ab_cdef;
    access            = '0;
    data_ram_error_in = 1'b0;
    tag_ram_error_in  = '0;
  end

  // One access cycle, then idle with changing data
  task automatic issue(input op_e op, input phase_e ph, input logic wb, input logic par_bad, input logic ram_err);
    @(negedge clk);
    pat = {pat[62:0], pat[63] ^ pat[60]};
    access.valid      = 1'b1;
    access.op         = op;
    access.phase      = ph;
    access.write_back = wb;
    // Tag reads carry only the low byte so both parity readings agree
    access.rd_data    = (ph == PH_TAG_READ) ? {56'h0, pat[7:0]} : pat;
    for (int i = 0; i < DATA_BYTES; i++) begin
      access.rd_par[i] = ^access.rd_data[8*i +: 8];
    end
    access.rd_par[0]  = access.rd_par[0] ^ par_bad;
    data_ram_error_in = ram_err && (ph == PH_DATA_READ || ph == PH_DATA_WRITE);
    tag_ram_error_in  = (ram_err && (ph == PH_TAG_READ || ph == PH_TAG_WRITE)) ? 8'h04 : 8'h00;
    @(negedge clk);
    access.valid      = 1'b0;
    access.rd_data    = ~access.rd_data;
    access.rd_par     = ~access.rd_par;
    data_ram_error_in = 1'b0;
    tag_ram_error_in  = '0;
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import cache_err_pkg::*;

  logic                  clk;
  logic                  rstn;
  ram_access_s           access;
  logic                  data_ram_error_in;
  logic [TAG_RAMS-1:0]   tag_ram_error_in;
  ram_write_s            wr;
  logic [N_IRQ-1:0]      irq_clear;
  logic [N_EXT_IRQ-1:0]  ext_irq;
  logic                  tag_read_parity_irq, tag_read_error_irq, data_read_parity_irq;
  logic                  data_read_error_irq, data_write_error_irq, tag_write_error_irq;
  logic                  combined_irq;
  op_result_s            result;
  logic [DATA_BYTES-1:0] data_wr_par;
  logic                  tag_wr_par;
  logic [N_IRQ-1:0]      irqv;
  logic [DATA_BYTES-1:0] e_par;
  int                    n_fail, comparisons;

  assign irqv = {tag_write_error_irq, data_write_error_irq, data_read_error_irq,
                 data_read_parity_irq, tag_read_error_irq, tag_read_parity_irq};

  ram_side_model ram_side_model_i (.clk(clk), .access(access), .data_ram_error_in(data_ram_error_in),
    .tag_ram_error_in(tag_ram_error_in));

  cache_ram_error_reporting cache_ram_error_reporting_i (.clk(clk), .rstn(rstn), .access(access),
    .data_ram_error_in(data_ram_error_in), .tag_ram_error_in(tag_ram_error_in), .wr(wr),
    .irq_clear(irq_clear), .ext_irq(ext_irq), .tag_read_parity_irq(tag_read_parity_irq),
    .tag_read_error_irq(tag_read_error_irq), .data_read_parity_irq(data_read_parity_irq),
    .data_read_error_irq(data_read_error_irq), .data_write_error_irq(data_write_error_irq),
    .tag_write_error_irq(tag_write_error_irq), .combined_irq(combined_irq), .result(result),
    .data_wr_par(data_wr_par), .tag_wr_par(tag_wr_par));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One access, verdict check, then clear all lines
  task automatic acc(input op_e op, input phase_e ph, input logic wb, input logic par, input logic ram,
                     input logic [N_IRQ-1:0] e_irq, input logic [2:0] e_res);
    ram_side_model_i.issue(op, ph, wb, par, ram);
    `CHK(irqv, e_irq)
    `CHK(result, e_res)
    `CHK(combined_irq, |e_irq)
    irq_clear = '1;
    @(negedge clk);
    irq_clear = '0;
    `CHK(irqv, 6'h00)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_tag_read;
    for (int i = 0; i < 6; i++) begin
      acc(op_e'(i), PH_TAG_READ, 1'b0, 1'b1, 1'b0, 6'h01, {i != 0, 2'b00});
      acc(op_e'(i), PH_TAG_READ, 1'b0, 1'b0, 1'b1, 6'h02, {i != 0, 2'b00});
    end
  endtask

  task automatic t_data_read;
    op_e ops [3] = '{OP_ALLOC, OP_CLEAN, OP_CLEAN_INV};
    acc(OP_SLAVE_READ, PH_DATA_READ, 1'b0, 1'b0, 1'b1, 6'h02, 3'b000);
    acc(OP_SLAVE_READ, PH_DATA_READ, 1'b0, 1'b1, 1'b0, 6'h01, 3'b000);
    foreach (ops[i]) begin
      acc(ops[i], PH_DATA_READ, 1'b0, 1'b1, 1'b0, 6'h04, 3'b000);
      acc(ops[i], PH_DATA_READ, 1'b0, 1'b0, 1'b1, 6'h08, 3'b010);
    end
  endtask

  task automatic t_writes;
    acc(OP_ALLOC, PH_TAG_WRITE, 1'b0, 1'b0, 1'b1, 6'h20, 3'b000);
    acc(OP_INVAL, PH_TAG_WRITE, 1'b0, 1'b0, 1'b1, 6'h20, 3'b000);
    acc(OP_CLEAN_INV, PH_TAG_WRITE, 1'b0, 1'b0, 1'b1, 6'h20, 3'b000);
    acc(OP_ALLOC, PH_DATA_WRITE, 1'b0, 1'b0, 1'b1, 6'h10, 3'b000);
    acc(OP_SB_WRITE, PH_DATA_WRITE, 1'b1, 1'b0, 1'b1, 6'h10, 3'b001);
    acc(OP_SB_WRITE, PH_DATA_WRITE, 1'b0, 1'b0, 1'b1, 6'h10, 3'b000);
    // Write phases ignore read parity
    acc(OP_ALLOC, PH_DATA_WRITE, 1'b0, 1'b1, 1'b0, 6'h00, 3'b000);
  endtask

  task automatic t_sticky;
    ram_side_model_i.issue(OP_ALLOC, PH_DATA_READ, 1'b0, 1'b0, 1'b1);
    repeat (3) @(negedge clk);
    `CHK(irqv, 6'h08)
    `CHK(result, 3'b000)
    irq_clear = 6'h01;
    @(negedge clk);
    `CHK(irqv, 6'h08)
    irq_clear = 6'h08;
    @(negedge clk);
    irq_clear = '0;
    `CHK(combined_irq, 1'b0)
    for (int i = 0; i < N_EXT_IRQ; i++) begin
      ext_irq = 3'h1 << i;
      @(negedge clk);
      `CHK(combined_irq, 1'b1)
    end
    ext_irq = '0;
    @(negedge clk);
    `CHK(combined_irq, 1'b0)
    // Clear standing in the set cycle loses
    irq_clear = 6'h08;
    ram_side_model_i.issue(OP_CLEAN, PH_DATA_READ, 1'b0, 1'b0, 1'b1);
    `CHK(irqv, 6'h08)
    `CHK(result, 3'b010)
    @(negedge clk);
    irq_clear = '0;
    `CHK(irqv, 6'h00)
  endtask

  task automatic t_parity;
    logic [DATA_W-1:0] vals [3] = '{64'h0000_0000_0000_0001, 64'hff01_8000_7f3c_00a5, 64'hffff_ffff_ffff_ffff};
    foreach (vals[k]) begin
      wr.data = vals[k];
      wr.tag  = vals[k][TAG_W+2:3];
      for (int i = 0; i < DATA_BYTES; i++) begin
        e_par[i] = ^vals[k][8*i +: 8];
      end
      @(negedge clk);
      `CHK(data_wr_par, e_par)
      `CHK(tag_wr_par, ^vals[k][TAG_W+2:3])
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 20000);
    n_fail++;
    report_and_stop();
  end

  initial begin
    rstn      = 1'b0;
    wr        = '0;
    irq_clear = '0;
    ext_irq   = '0;
    repeat (3) @(negedge clk);
    `CHK(irqv, 6'h00)
    `CHK(result, 3'b000)
    rstn = 1'b1;
    t_tag_read();
    t_data_read();
    t_writes();
    t_sticky();
    t_parity();
    report_and_stop();
  end
endmodule
